// ---- pkg/pch_pkg.sv ----
/*
 * Constants, field layouts and carrier types for the configuration header block.
 * Assumes a single 50 MHz clock and a word-wide configuration access port.
 */
package pch_pkg;

	// ----------------------------------------------------------------
	// Header word offsets, byte addresses within the 64-byte header
	// ----------------------------------------------------------------
	localparam logic [5:0] PCH_OFS_ID = 6'h00;
	localparam logic [5:0] PCH_OFS_CMD = 6'h04;
	localparam logic [5:0] PCH_OFS_CLASS = 6'h08;
	localparam logic [5:0] PCH_OFS_MISC = 6'h0C;
	localparam logic [5:0] PCH_OFS_BAR_MEM = 6'h10;
	localparam logic [5:0] PCH_OFS_BAR_IO = 6'h14;
	localparam logic [5:0] PCH_OFS_BAR_LOC = 6'h18;
	localparam logic [5:0] PCH_OFS_BAR_ROM = 6'h30;
	localparam logic [5:0] PCH_OFS_IRQ = 6'h3C;

	// ----------------------------------------------------------------
	// Command word layout
	// ----------------------------------------------------------------
	localparam logic [15:0] PCH_CMD_RESET = 16'h0000;
	localparam logic [15:0] PCH_CMD_WR_MASK = 16'h0347;
	localparam int PCH_CMD_IO = 0;
	localparam int PCH_CMD_MEM = 1;
	localparam int PCH_CMD_MASTER = 2;
	localparam int PCH_CMD_PARITY = 6;
	localparam int PCH_CMD_SERR = 8;
	localparam int PCH_CMD_FBB = 9;

	// ----------------------------------------------------------------
	// Fixed read values of the other header fields, and the interrupt line reset value
	// ----------------------------------------------------------------
	localparam logic [15:0] PCH_STATUS_VALUE = 16'h0280;
	localparam logic [7:0] PCH_REVISION = 8'h03;
	localparam logic [23:0] PCH_CLASS = 24'h0C0200;
	localparam logic [7:0] PCH_LINE_SIZE = 8'h00;
	localparam logic [7:0] PCH_BURST_LIMIT = 8'h00;
	localparam logic [7:0] PCH_HEADER_KIND = 8'h00;
	localparam logic [7:0] PCH_SELF_TEST = 8'h80;
	localparam logic [7:0] PCH_IRQ_PIN = 8'h01;
	localparam logic [7:0] PCH_MIN_GRANT = 8'h00;
	localparam logic [7:0] PCH_MAX_LATENCY = 8'h00;
	localparam logic [7:0] PCH_IRQ_LINE_RESET = 8'h00;

	// Identification value before the local processor loads it; the value is arbitrary.
	localparam logic [31:0] PCH_ID_DEFAULT = 32'hA5A5_5A5A;

	// ----------------------------------------------------------------
	// Window base registers: writable address bits and fixed flag bits
	// ----------------------------------------------------------------
	localparam logic [31:0] PCH_BAR_RESET = 32'h0000_0000;
	localparam logic [31:0] PCH_BAR_MEM_MASK = 32'hFFFF_FF80;
	localparam logic [31:0] PCH_BAR_MEM_FLAG = 32'h0000_0000;
	localparam logic [31:0] PCH_BAR_IO_MASK = 32'hFFFF_FF80;
	localparam logic [31:0] PCH_BAR_IO_FLAG = 32'h0000_0001;
	localparam logic [31:0] PCH_BAR_LOC_MASK = 32'hFFF0_0000;
	localparam logic [31:0] PCH_BAR_LOC_FLAG = 32'h0000_0000;
	localparam logic [31:0] PCH_BAR_ROM_MASK = 32'hFFFF_0001;
	localparam logic [31:0] PCH_BAR_ROM_FLAG = 32'h0000_0000;
	localparam int PCH_ROM_ENABLE = 0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] addr;
		logic [3:0] be;
		logic [31:0] data;
	} pch_cfg_req_t;

	typedef struct packed {
		logic valid;
		logic is_io;
		logic is_mem;
		logic [31:0] addr;
	} pch_bus_cyc_t;

endpackage

// ---- rtl/pch_cmd_reg.sv ----
/*
 * Command word of the configuration header with per-byte write.
 * Assumes a reset already synchronised to the clock and a one-cycle write strobe.
 */
`timescale 1ns/1ns
module pch_cmd_reg (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_wr,
	input wire logic [1:0] i_be,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_cmd
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [15:0] cmd_r;
	logic [15:0] cmd_nxt;

	always_comb begin
		cmd_nxt = cmd_r;
		if (i_wr && i_be[0]) begin
			cmd_nxt[7:0] = i_wdata[7:0];
		end
		if (i_wr && i_be[1]) begin
			cmd_nxt[15:8] = i_wdata[15:8];
		end
		// Unsupported and reserved bits never store anything.
		cmd_nxt = cmd_nxt & pch_pkg::PCH_CMD_WR_MASK;
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cmd_r <= pch_pkg::PCH_CMD_RESET;
		end else begin
			cmd_r <= cmd_nxt;
		end
	end

	assign o_cmd = cmd_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_cmd_fixed_zero: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		(o_cmd & ~pch_pkg::PCH_CMD_WR_MASK) == 16'h0000)
		else $error("Reserved command bit reads as one.");

	a_cmd_low_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		(i_wr && i_be[0]) |=> o_cmd[7:0] == ($past(i_wdata[7:0]) & pch_pkg::PCH_CMD_WR_MASK[7:0]))
		else $error("Low command byte not written.");

	a_cmd_high_kept: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		(i_wr && !i_be[1]) |=> $stable(o_cmd[15:8]))
		else $error("Disabled high command byte changed.");

endmodule

// ---- rtl/pch_config_header.sv ----
/*
 * Type-0 configuration header: identification, command and window base registers,
 * plus the decode, master, parity and fast back-to-back gating driven by the command word.
 * Assumes configuration accesses and bus-cycle indications synchronous to i_clock.
 */
// Overview of operation
// - Header fields sit at fixed offsets; window bases at 10h, 14h, 18h, 30h; rest reserved.
// - Header resets on power-up and bus reset only, never on adapter software reset.
// - Identification word at 00h holds vendor low, device high; bus writes ignored.
// - Local processor loads identification after reset, then the init-done flag sets.
// - Command resets to zero; then only configuration accesses are answered.
// - Command bit 0 gates claiming of I/O accesses.
// - Command bit 1 gates claiming of memory accesses.
// - Command bit 2 permits starting master transactions.
// - Command bits 3, 4, 5 are unsupported, unwritable, read zero.
// - Command bit 6 enables parity checking; when zero, parity errors are ignored.
// - Command bit 7 is fixed zero; no address or data stepping.
// - Bit 8 enables the system-error driver; address parity reported only with bits 8 and 6.
// - Bit 9 allows fast back-to-back to other targets; else same target only.
`timescale 1ns/1ns
module pch_config_header (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire pch_pkg::pch_cfg_req_t i_cfg_req,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_ack,
	input wire logic i_local_cfg_id_we,
	input wire logic [31:0] i_local_cfg_id_data,
	input wire logic i_local_cfg_done,
	output logic o_local_init_done,
	input wire pch_pkg::pch_bus_cyc_t i_bus_cyc,
	output logic o_io_claim,
	output logic o_mem_claim,
	input wire logic i_master_req,
	output logic o_master_start,
	input wire logic i_addr_parity_err,
	input wire logic i_data_parity_err,
	output logic o_perr_report,
	output logic o_serr_b_o,
	output logic o_serr_oe,
	input wire logic i_fbb_req,
	input wire logic i_fbb_same_target,
	output logic o_fbb_permit,
	output logic [15:0] o_cmd
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] bar_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be, input logic [31:0] mask, input logic [31:0] flag);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		bar_merge = (res & mask) | flag;
	endfunction

	function automatic logic win_hit(input logic [31:0] addr, input logic [31:0] base,
		input logic [31:0] mask);
		logic [31:0] amask;
		amask = mask & 32'hFFFF_FFF0;
		win_hit = (addr & amask) == (base & amask);
	endfunction

	function automatic logic ofs_is(input logic [5:0] addr, input logic [5:0] ofs);
		ofs_is = addr[5:2] == ofs[5:2];
	endfunction

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	// The header deliberately has no software reset input, so an adapter
	// self-reset cannot disturb addresses the host has already assigned.
	logic rst_meta_r;
	logic rst_sync_r;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// Configuration write and read strobes
	// ----------------------------------------------------------------
	logic cfg_wr;
	logic cfg_rd;

	assign cfg_wr = i_cfg_req.valid && i_cfg_req.write;
	assign cfg_rd = i_cfg_req.valid && !i_cfg_req.write;

	// ----------------------------------------------------------------
	// Command word
	// ----------------------------------------------------------------
	logic [15:0] cmd;

	pch_cmd_reg u_cmd (
		.i_clock(i_clock),
		.i_rst_b(rst_sync_r),
		.i_wr(cfg_wr && ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_CMD)),
		.i_be(i_cfg_req.be[1:0]),
		.i_wdata(i_cfg_req.data[15:0]),
		.o_cmd(cmd)
	);

	assign o_cmd = cmd;

	// ----------------------------------------------------------------
	// Identification word and local init flag
	// ----------------------------------------------------------------
	logic [31:0] id_r;
	logic init_done_r;

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			id_r <= pch_pkg::PCH_ID_DEFAULT;
		end else if (i_local_cfg_id_we) begin
			// Only the local side path loads it; configuration writes never reach here.
			id_r <= i_local_cfg_id_data;
		end
	end

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			init_done_r <= 1'b0;
		end else if (i_local_cfg_done) begin
			init_done_r <= 1'b1;
		end
	end

	assign o_local_init_done = init_done_r;

	// ----------------------------------------------------------------
	// Window bases and interrupt line
	// ----------------------------------------------------------------
	logic [31:0] bar_mem_r;
	logic [31:0] bar_io_r;
	logic [31:0] bar_loc_r;
	logic [31:0] bar_rom_r;
	logic [7:0] irq_line_r;

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			bar_mem_r <= pch_pkg::PCH_BAR_RESET | pch_pkg::PCH_BAR_MEM_FLAG;
			bar_io_r <= pch_pkg::PCH_BAR_RESET | pch_pkg::PCH_BAR_IO_FLAG;
			bar_loc_r <= pch_pkg::PCH_BAR_RESET | pch_pkg::PCH_BAR_LOC_FLAG;
			bar_rom_r <= pch_pkg::PCH_BAR_RESET | pch_pkg::PCH_BAR_ROM_FLAG;
		end else if (cfg_wr) begin
			if (ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_BAR_MEM)) begin
				bar_mem_r <= bar_merge(bar_mem_r, i_cfg_req.data, i_cfg_req.be,
					pch_pkg::PCH_BAR_MEM_MASK, pch_pkg::PCH_BAR_MEM_FLAG);
			end
			if (ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_BAR_IO)) begin
				bar_io_r <= bar_merge(bar_io_r, i_cfg_req.data, i_cfg_req.be,
					pch_pkg::PCH_BAR_IO_MASK, pch_pkg::PCH_BAR_IO_FLAG);
			end
			if (ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_BAR_LOC)) begin
				bar_loc_r <= bar_merge(bar_loc_r, i_cfg_req.data, i_cfg_req.be,
					pch_pkg::PCH_BAR_LOC_MASK, pch_pkg::PCH_BAR_LOC_FLAG);
			end
			if (ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_BAR_ROM)) begin
				bar_rom_r <= bar_merge(bar_rom_r, i_cfg_req.data, i_cfg_req.be,
					pch_pkg::PCH_BAR_ROM_MASK, pch_pkg::PCH_BAR_ROM_FLAG);
			end
		end
	end

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			irq_line_r <= pch_pkg::PCH_IRQ_LINE_RESET;
		end else if (cfg_wr && ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_IRQ) && i_cfg_req.be[0]) begin
			irq_line_r <= i_cfg_req.data[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Configuration read path
	// ----------------------------------------------------------------
	logic [31:0] rd_val;

	always_comb begin
		rd_val = 32'h0000_0000;
		case (i_cfg_req.addr[5:2])
			pch_pkg::PCH_OFS_ID[5:2]: rd_val = id_r;
			pch_pkg::PCH_OFS_CMD[5:2]: rd_val = {pch_pkg::PCH_STATUS_VALUE, cmd};
			pch_pkg::PCH_OFS_CLASS[5:2]: rd_val = {pch_pkg::PCH_CLASS, pch_pkg::PCH_REVISION};
			pch_pkg::PCH_OFS_MISC[5:2]: rd_val = {pch_pkg::PCH_SELF_TEST,
				pch_pkg::PCH_HEADER_KIND, pch_pkg::PCH_BURST_LIMIT, pch_pkg::PCH_LINE_SIZE};
			pch_pkg::PCH_OFS_BAR_MEM[5:2]: rd_val = bar_mem_r;
			pch_pkg::PCH_OFS_BAR_IO[5:2]: rd_val = bar_io_r;
			pch_pkg::PCH_OFS_BAR_LOC[5:2]: rd_val = bar_loc_r;
			pch_pkg::PCH_OFS_BAR_ROM[5:2]: rd_val = bar_rom_r;
			pch_pkg::PCH_OFS_IRQ[5:2]: rd_val = {pch_pkg::PCH_MAX_LATENCY,
				pch_pkg::PCH_MIN_GRANT, pch_pkg::PCH_IRQ_PIN, irq_line_r};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Configuration accesses are answered whatever the command word holds.
	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_cfg_rdata <= 32'h0000_0000;
			o_cfg_ack <= 1'b0;
		end else begin
			o_cfg_ack <= i_cfg_req.valid;
			if (cfg_rd) begin
				o_cfg_rdata <= rd_val;
			end
		end
	end

	// ----------------------------------------------------------------
	// Decode, master and transfer gating
	// ----------------------------------------------------------------
	logic mem_hit;
	logic io_hit;

	assign io_hit = win_hit(i_bus_cyc.addr, bar_io_r, pch_pkg::PCH_BAR_IO_MASK);
	assign mem_hit = win_hit(i_bus_cyc.addr, bar_mem_r, pch_pkg::PCH_BAR_MEM_MASK)
		|| win_hit(i_bus_cyc.addr, bar_loc_r, pch_pkg::PCH_BAR_LOC_MASK)
		|| (bar_rom_r[pch_pkg::PCH_ROM_ENABLE]
		&& win_hit(i_bus_cyc.addr, bar_rom_r, pch_pkg::PCH_BAR_ROM_MASK));

	// A zero command word clears every enable, so nothing but configuration is claimed.
	assign o_io_claim = i_bus_cyc.valid && i_bus_cyc.is_io && io_hit
		&& cmd[pch_pkg::PCH_CMD_IO];
	assign o_mem_claim = i_bus_cyc.valid && i_bus_cyc.is_mem && mem_hit
		&& cmd[pch_pkg::PCH_CMD_MEM];
	assign o_master_start = i_master_req && cmd[pch_pkg::PCH_CMD_MASTER];
	assign o_fbb_permit = i_fbb_req
		&& (cmd[pch_pkg::PCH_CMD_FBB] || i_fbb_same_target);

	// ----------------------------------------------------------------
	// Parity response and system-error driver
	// ----------------------------------------------------------------
	// The system-error pin is open drain: it only ever pulls low.
	assign o_serr_b_o = 1'b0;

	always_ff @(posedge i_clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			o_perr_report <= 1'b0;
			o_serr_oe <= 1'b0;
		end else begin
			o_perr_report <= i_data_parity_err && cmd[pch_pkg::PCH_CMD_PARITY];
			o_serr_oe <= i_addr_parity_err && cmd[pch_pkg::PCH_CMD_PARITY]
				&& cmd[pch_pkg::PCH_CMD_SERR];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_cfg_read;
		cfg_rd;
	endsequence

	sequence s_id_write;
		cfg_wr && ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_ID) && !i_local_cfg_id_we;
	endsequence

	a_cfg_read_ack: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		s_cfg_read |=> o_cfg_ack && o_cfg_rdata == $past(rd_val))
		else $error("Configuration read not answered next cycle.");

	a_id_read_only: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		s_id_write |=> $stable(id_r))
		else $error("Identification word changed by a bus write.");

	a_init_done_set: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		i_local_cfg_done |=> o_local_init_done [*3])
		else $error("Init-done flag not set and held.");

	a_io_claim_gate: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		o_io_claim |-> cmd[0] && i_bus_cyc.is_io)
		else $error("I/O access claimed while disabled.");

	a_mem_claim_gate: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		(i_bus_cyc.valid && i_bus_cyc.is_mem && mem_hit && cmd[1]) |-> o_mem_claim)
		else $error("Enabled memory access not claimed.");

	a_zero_cmd_quiet: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		(cmd == 16'h0000) |-> !(o_io_claim || o_mem_claim || o_master_start))
		else $error("Activity while command word is zero.");

	a_master_gate: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		o_master_start == (i_master_req && cmd[2]))
		else $error("Master start disagrees with enable.");

	a_parity_ignore: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		(i_data_parity_err && !cmd[6]) |=> !o_perr_report)
		else $error("Parity error reported while checking is off.");

	a_serr_both_bits: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		o_serr_oe |-> $past(i_addr_parity_err && cmd[8] && cmd[6]))
		else $error("System error driven without both enables.");

	a_fbb_other_target: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		(i_fbb_req && !i_fbb_same_target) |-> (o_fbb_permit == cmd[9]))
		else $error("Fast back-to-back to other target misgated.");

	a_stepping_off: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		cfg_rd && ofs_is(i_cfg_req.addr, pch_pkg::PCH_OFS_CMD) |=> !o_cfg_rdata[7])
		else $error("Wait cycle control reads as one.");

	a_unsup_zero: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		cmd[5:3] == 3'b000)
		else $error("Unsupported command bit set.");

	a_bar_io_flag: assert property (@(posedge i_clock) disable iff (!rst_sync_r)
		bar_io_r[0] && bar_mem_r[0] == 1'b0)
		else $error("Window base flag bits wrong.");

endmodule

// ---- test/pch_host_model.sv ----
/*
 * Behavioural host bridge that issues configuration cycles to the header block.
 * Assumes the bench calls cfg_access only after reset is released, one call at a time.
 */
`timescale 1ns/1ns
module pch_host_model (
	input wire logic i_clock,
	input wire logic i_cfg_ack,
	input wire logic [31:0] i_cfg_rdata,
	output pch_pkg::pch_cfg_req_t o_cfg_req
);
	// ----------------------------------------------------------------
	// Configuration cycle
	// ----------------------------------------------------------------
	// Released lines carry the inverse of the last value, so a design that samples
	// them outside the request cycle reads garbage instead of a lucky match.
	initial begin
		o_cfg_req = '0;
	end

	task automatic cfg_access(input logic wr, input logic [5:0] addr, input logic [3:0] be,
		input logic [31:0] wdata, output logic [31:0] rdata, output logic ok);
		@(negedge i_clock);
		o_cfg_req = '{valid: 1'h1, write: wr, addr: addr, be: be, data: wdata};
		@(negedge i_clock);
		o_cfg_req = '{valid: 1'h0, write: ~wr, addr: ~addr, be: ~be, data: ~wdata};
		ok = i_cfg_ack;
		rdata = i_cfg_rdata;
	endtask
endmodule

// ---- test/pch_config_header_tb.sv ----
/*
 * Self-checking bench for the configuration header block.
 * Assumes the host model drives the configuration port; all other inputs are driven here.
 */
`timescale 1ns/1ns
module pch_config_header_tb;
	typedef struct packed {
		logic wr;
		logic [5:0] a;
		logic [3:0] be;
		logic [31:0] d;
		logic [31:0] exp;
	} pch_tb_row_t;

	localparam pch_tb_row_t rows [22] = '{
		'{1'h1, 6'h04, 4'h3, 32'hFFFF_FFFF, 32'h0},
		'{1'h0, 6'h04, 4'h0, 32'h0, 32'h0280_0347},
		'{1'h1, 6'h04, 4'h1, 32'h0, 32'h0},
		'{1'h0, 6'h04, 4'h0, 32'h0, 32'h0280_0300},
		'{1'h1, 6'h00, 4'hF, 32'h1234_5678, 32'h0},
		'{1'h0, 6'h00, 4'h0, 32'h0, 32'hA5A5_5A5A},
		'{1'h1, 6'h10, 4'hF, 32'hFFFF_FFFF, 32'h0},
		'{1'h0, 6'h10, 4'h0, 32'h0, 32'hFFFF_FF80},
		'{1'h1, 6'h10, 4'h2, 32'h0, 32'h0},
		'{1'h0, 6'h10, 4'h0, 32'h0, 32'hFFFF_0080},
		'{1'h1, 6'h10, 4'h2, 32'hFFFF_FFFF, 32'h0},
		'{1'h1, 6'h14, 4'hF, 32'hFFFF_FFFF, 32'h0},
		'{1'h0, 6'h14, 4'h0, 32'h0, 32'hFFFF_FF81},
		'{1'h1, 6'h18, 4'hF, 32'hFFFF_FFFF, 32'h0},
		'{1'h0, 6'h18, 4'h0, 32'h0, 32'hFFF0_0000},
		'{1'h1, 6'h30, 4'hF, 32'hFFFF_FFFF, 32'h0},
		'{1'h0, 6'h30, 4'h0, 32'h0, 32'hFFFF_0001},
		'{1'h0, 6'h1C, 4'h0, 32'h0, 32'h0},
		'{1'h1, 6'h3C, 4'h1, 32'hFFFF_FFFF, 32'h0},
		'{1'h0, 6'h3C, 4'h0, 32'h0, 32'h0000_01FF},
		'{1'h0, 6'h08, 4'h0, 32'h0, 32'h0C02_0003},
		'{1'h0, 6'h0C, 4'h0, 32'h0, 32'h8000_0000}
	};
	localparam logic [15:0] cmds [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
		16'h0040, 16'h0100, 16'h0140, 16'h0200};

	logic i_clock = 1'h0;
	logic rst_b = 1'h0;
	pch_pkg::pch_cfg_req_t cfg_req;
	pch_pkg::pch_bus_cyc_t bus_cyc = '0;
	logic [31:0] cfg_rdata, id_data = 32'h0, q;
	logic cfg_ack, id_we = 1'h0, cfg_done = 1'h0, init_done, io_claim, mem_claim;
	logic master_req = 1'h0, master_start, a_err = 1'h0, d_err = 1'h0, perr, serr_b, serr_oe;
	logic fbb_req = 1'h0, fbb_same = 1'h0, fbb_permit;
	logic [15:0] cmd, c;
	int err_count = 0, total_checks = 0, cycles = 0;

	always #10 i_clock = ~i_clock;

	pch_host_model u_pch_host_model (.i_clock(i_clock), .i_cfg_ack(cfg_ack),
		.i_cfg_rdata(cfg_rdata), .o_cfg_req(cfg_req));

	pch_config_header u_pch_config_header (.i_clock(i_clock), .i_rst_b(rst_b),
		.i_cfg_req(cfg_req), .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack),
		.i_local_cfg_id_we(id_we), .i_local_cfg_id_data(id_data),
		.i_local_cfg_done(cfg_done), .o_local_init_done(init_done), .i_bus_cyc(bus_cyc),
		.o_io_claim(io_claim), .o_mem_claim(mem_claim), .i_master_req(master_req),
		.o_master_start(master_start), .i_addr_parity_err(a_err),
		.i_data_parity_err(d_err), .o_perr_report(perr), .o_serr_b_o(serr_b),
		.o_serr_oe(serr_oe), .i_fbb_req(fbb_req), .i_fbb_same_target(fbb_same),
		.o_fbb_permit(fbb_permit), .o_cmd(cmd));

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic acc(input logic wr, input logic [5:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic [31:0] rd);
		logic ok;
		u_pch_host_model.cfg_access(wr, a, be, d, rd, ok);
		chk({31'h0, ok}, 32'h1);
	endtask

	// The ceiling is far above the roughly 110 cycles the sequence needs.
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			$display("[ERR] %0t run did not finish", $time);
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge i_clock);
		@(negedge i_clock);
		rst_b = 1'h1;
		repeat (3) @(negedge i_clock);
		chk({16'h0, cmd}, 32'h0);
		chk({31'h0, init_done}, 32'h0);
		acc(1'h0, 6'h04, 4'h0, 32'h0, q);
		chk(q, 32'h0280_0000);
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].a, rows[i].be, rows[i].d, q);
			if (!rows[i].wr) chk(q, rows[i].exp);
		end
		@(negedge i_clock);
		id_we = 1'h1;
		id_data = 32'h5A3C_C3A5;
		@(negedge i_clock);
		id_we = 1'h0;
		cfg_done = 1'h1;
		@(negedge i_clock);
		cfg_done = 1'h0;
		chk({31'h0, init_done}, 32'h1);
		acc(1'h0, 6'h00, 4'h0, 32'h0, q);
		chk(q, 32'h5A3C_C3A5);
		foreach (cmds[k]) begin
			c = cmds[k];
			acc(1'h1, 6'h04, 4'h3, {16'hFFFF, c}, q);
			chk({16'h0, cmd}, {16'h0, c});
			@(negedge i_clock);
			bus_cyc = '{valid: 1'h1, is_io: 1'h1, is_mem: 1'h0, addr: 32'hFFFF_FF88};
			master_req = 1'h1;
			fbb_req = 1'h1;
			fbb_same = 1'h0;
			d_err = 1'h1;
			#1;
			chk({31'h0, io_claim}, {31'h0, c[0]});
			chk({31'h0, master_start}, {31'h0, c[2]});
			chk({31'h0, fbb_permit}, {31'h0, c[9]});
			@(negedge i_clock);
			bus_cyc = '{valid: 1'h1, is_io: 1'h0, is_mem: 1'h1, addr: 32'hFFFF_FF84};
			fbb_same = 1'h1;
			d_err = 1'h0;
			a_err = 1'h1;
			#1;
			chk({31'h0, mem_claim}, {31'h0, c[1]});
			chk({31'h0, fbb_permit}, 32'h1);
			chk({31'h0, perr}, {31'h0, c[6]});
			@(negedge i_clock);
			bus_cyc = '{valid: 1'h1, is_io: 1'h1, is_mem: 1'h1, addr: 32'h0000_1000};
			a_err = 1'h0;
			master_req = 1'h0;
			fbb_req = 1'h0;
			#1;
			chk({31'h0, serr_oe}, {31'h0, c[6] & c[8]});
			chk({31'h0, serr_b}, 32'h0);
			chk({30'h0, io_claim, mem_claim}, 32'h0);
			chk({31'h0, perr}, 32'h0);
		end
		// No adapter software reset exists at the ports; only the bus reset is exercised.
		@(negedge i_clock);
		rst_b = 1'h0;
		#1;
		chk({15'h0, init_done, cmd}, 32'h0);
		repeat (2) @(negedge i_clock);
		rst_b = 1'h1;
		repeat (3) @(negedge i_clock);
		acc(1'h0, 6'h00, 4'h0, 32'h0, q);
		chk(q, pch_pkg::PCH_ID_DEFAULT);
		acc(1'h0, 6'h10, 4'h0, 32'h0, q);
		chk(q, 32'h0);
		report_and_stop();
	end
endmodule
